// >>> hdl/sipo_pkg.sv
/*
 * Package for the serial-in parallel-out latch: widths, stage count,
 * reset values and the packed carrier types shared by the design files.
 * Assumes a single 125 MHz system clock and no software registers.
 */
package sipo_pkg;

    localparam int unsigned STAGES = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned SYNC_LEN = 2;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] STORE_RESET = 8'h00;

    // Levels of the link pins after two-flop synchronisation
    typedef struct packed {
        logic serial_data_in;
        logic shift_clock;
        logic shift_clear_n;
        logic store_clock;
        logic output_enable_n;
    } sipo_pins_type;

    // Synchroniser levels in reset: idle clocks, clear off, enable high,
    // so the parallel pins cannot be driven before the host is seen
    localparam sipo_pins_type PINS_RESET = '{
        serial_data_in: 1'h0,
        shift_clock: 1'h0,
        shift_clear_n: 1'h1,
        store_clock: 1'h0,
        output_enable_n: 1'h1
    };

    // Parallel output pins: value and enable
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } sipo_par_type;

endpackage

// >>> hdl/sipo_sync.sv
/*
 * Two-flop synchroniser for the asynchronous link pins.
 * Assumes the pins are quasi-static relative to the 8 ns clock.
 */
module sipo_sync #(
    parameter int unsigned WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sipo_sync_state_type;

    sipo_sync_state_type st_q;
    sipo_sync_state_type st_d;

    always_comb begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.meta <= RESET_VALUE;
            st_q.stable <= RESET_VALUE;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stable;

endmodule

// >>> hdl/sipo_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; full and empty are exact. The drain side is taken
 * from registers, so the head byte is prepared one cycle ahead.
 */
module sipo_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic not_empty;
        logic [WIDTH-1:0] head;
    } sipo_fifo_state_type;

    sipo_fifo_state_type st_q;
    sipo_fifo_state_type st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (st_q.count != (AW+1)'(DEPTH));
    assign out_valid = st_q.not_empty;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = st_q.head;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wr = st_q.wr + AW'(1);
        end
        if (pop) begin
            st_d.rd = st_q.rd + AW'(1);
        end
        if (push && !pop) begin
            st_d.count = st_q.count + (AW+1)'(1);
        end else if (pop && !push) begin
            st_d.count = st_q.count - (AW+1)'(1);
        end
        st_d.not_empty = (st_d.count != '0);
        // A byte written into the next read slot bypasses the memory
        if (push && st_q.wr == st_d.rd) begin
            st_d.head = in_data;
        end else begin
            st_d.head = mem[st_d.rd];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Storage needs no reset; only read when counted valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_q.wr] <= in_data;
        end
    end

endmodule

// >>> hdl/sipo_latch.sv
/*
 * Serial-in parallel-out latch: eight shift stages feeding an eight-bit
 * storage register with tri-stated parallel outputs and a cascade output.
 * Assumes the host's pins are asynchronous to clk and change slower than
 * a few clk periods; link clock edges are found by sampling.
 */
// Functional notes
// - Eight shift stages feed an eight-bit storage register.
// - Storage register drives eight tri-state parallel outputs.
// - Shift and storage each have an independent clock input.
// - Both clocks act only on rising edges.
// - Low clear zeroes all shift stages at once; storage untouched.
// - Rising shift clock: stage one takes serial input, others shift.
// - Rising storage clock copies all eight shift stages.
// - Enable high floats parallel outputs; cascade always driven.
// - Serial cascade output lets several devices chain.
// - Clocks tied together: storage lags shift by one pulse.
module sipo_latch (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link pins from the host
    input wire logic serial_data_in,
    input wire logic shift_clock,
    input wire logic shift_clear_n,
    input wire logic store_clock,
    input wire logic output_enable_n,
    // Parallel outputs: value and drive enable
    output logic [7:0] par_out,
    output logic [7:0] par_oe,
    // Cascade output, never floated
    output logic cascade_out,
    // Stored bytes stream, one per storage edge while the FIFO has room
    output logic store_valid,
    input wire logic store_ready,
    output logic [7:0] store_data
);

    typedef struct packed {
        logic shift_clock_prev;
        logic store_clock_prev;
        logic [7:0] shift_stages;
        logic [7:0] storage;
        logic [7:0] par_out;
        logic [7:0] par_oe;
        logic cascade;
        logic fifo_push;
        logic [7:0] fifo_word;
        logic dropped;
    } sipo_state_type;

    sipo_state_type st_q;
    sipo_state_type st_d;
    sipo_pkg::sipo_pins_type pins;
    sipo_pkg::sipo_pins_type pins_raw;
    logic rst_n;
    logic [1:0] rst_sync_q;
    logic shift_rise;
    logic store_rise;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;

    function automatic logic rising(input logic prev, input logic now);
        return now && !prev;
    endfunction

    // Reset released through two flops; kept apart from the main state,
    // being the only register cleared by the raw pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign pins_raw.serial_data_in = serial_data_in;
    assign pins_raw.shift_clock = shift_clock;
    assign pins_raw.shift_clear_n = shift_clear_n;
    assign pins_raw.store_clock = store_clock;
    assign pins_raw.output_enable_n = output_enable_n;

    sipo_sync #(
        .WIDTH($bits(sipo_pkg::sipo_pins_type)),
        .RESET_VALUE(sipo_pkg::PINS_RESET)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // Each clock gets its own edge detector
    assign shift_rise = rising(st_q.shift_clock_prev, pins.shift_clock);
    assign store_rise = rising(st_q.store_clock_prev, pins.store_clock);

    always_comb begin
        st_d = st_q;
        st_d.shift_clock_prev = pins.shift_clock;
        st_d.store_clock_prev = pins.store_clock;
        st_d.fifo_push = 1'h0;
        // Storage samples pre-edge stages, so tied clocks lag
        if (store_rise) begin
            st_d.storage = st_q.shift_stages;
            st_d.fifo_push = 1'h1;
            st_d.fifo_word = st_q.shift_stages;
            st_d.dropped = !fifo_ready;
        end
        // Clear overrides shifting
        if (!pins.shift_clear_n) begin
            st_d.shift_stages = sipo_pkg::SHIFT_RESET;
        end else if (shift_rise) begin
            st_d.shift_stages = {st_q.shift_stages[6:0],
                                 pins.serial_data_in};
        end
        // Parallel pins follow storage, floated by enable high
        st_d.par_out = st_d.storage;
        st_d.par_oe = pins.output_enable_n ? 8'h00 : 8'hFF;
        // Cascade is last shift stage, not storage
        st_d.cascade = st_d.shift_stages[7];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.shift_clock_prev <= 1'h0;
            st_q.store_clock_prev <= 1'h0;
            st_q.shift_stages <= sipo_pkg::SHIFT_RESET;
            st_q.storage <= sipo_pkg::STORE_RESET;
            st_q.par_out <= sipo_pkg::STORE_RESET;
            st_q.par_oe <= 8'h00;
            st_q.cascade <= 1'h0;
            st_q.fifo_push <= 1'h0;
            st_q.fifo_word <= 8'h00;
            st_q.dropped <= 1'h0;
        end else begin
            st_q.shift_clock_prev <= st_d.shift_clock_prev;
            st_q.store_clock_prev <= st_d.store_clock_prev;
            st_q.shift_stages <= st_d.shift_stages;
            st_q.storage <= st_d.storage;
            st_q.par_out <= st_d.par_out;
            st_q.par_oe <= st_d.par_oe;
            st_q.cascade <= st_d.cascade;
            st_q.fifo_push <= st_d.fifo_push;
            st_q.fifo_word <= st_d.fifo_word;
            st_q.dropped <= st_d.dropped;
        end
    end

    // Host link cannot be stalled; a full FIFO drops the newest byte
    sipo_fifo #(
        .WIDTH(8),
        .DEPTH(sipo_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(st_q.fifo_push),
        .in_ready(fifo_ready),
        .in_data(st_q.fifo_word),
        .out_valid(fifo_valid),
        .out_ready(store_ready),
        .out_data(fifo_data)
    );

    assign par_out = st_q.par_out;
    assign par_oe = st_q.par_oe;
    assign cascade_out = st_q.cascade;
    assign store_valid = fifo_valid;
    assign store_data = fifo_data;

endmodule

// >>> sim/sipo_latch_assertions.sv
/* Checker on the latch ports, bound in by the bench.
   Assumes host pins stay put for several clk cycles between moves. */
module sipo_latch_assertions (
    // Clock and reset
    input logic clk,
    input logic arst_n,
    // Link pins
    input logic serial_data_in,
    input logic shift_clock,
    input logic shift_clear_n,
    input logic store_clock,
    input logic output_enable_n,
    // Parallel and cascade outputs
    input logic [7:0] par_out,
    input logic [7:0] par_oe,
    input logic cascade_out,
    // Stored byte stream
    input logic store_valid,
    input logic store_ready,
    input logic [7:0] store_data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Eight quiet samples cover the three to four clk pin-to-output latency
    a_oe_off:
        assert property (output_enable_n [*8] |-> par_oe == 8'h00)
        else $error("pins driven while disabled");
    a_oe_on:
        assert property (!output_enable_n [*8] |-> par_oe == 8'hFF)
        else $error("pins float while enabled");
    a_oe_all_bits:
        assert property (par_oe != 8'h00 |-> par_oe == 8'hFF)
        else $error("enables split");
    a_clear_zero:
        assert property (!shift_clear_n [*8] |-> !cascade_out)
        else $error("cascade set under clear");
    a_casc_hold:
        assert property ((shift_clear_n && $stable(shift_clock)) [*8]
            |-> $stable(cascade_out))
        else $error("cascade moved without rising shift edge");
    a_par_hold:
        assert property ($stable(store_clock) [*8] |-> $stable(par_out))
        else $error("storage moved without rising store edge");
    a_store_push:
        assert property ($rose(store_clock) |-> ##[3:7] store_valid)
        else $error("no stored byte after store edge");
    a_fifo_hold:
        assert property (store_valid && !store_ready
            |=> store_valid && $stable(store_data))
        else $error("head byte lost while stalled");
endmodule

// >>> sim/sipo_host.sv
/* Host model driving serial data and both link clocks at 80 ns.
   Assumes clk at 125 MHz; every pin moves 1 ns after a clk edge. */
module sipo_host (
    // Clock
    input logic clk,
    // Link pins
    output logic serial_data_in,
    output logic shift_clock,
    output logic shift_clear_n,
    output logic store_clock,
    output logic output_enable_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_data_in = 1'b0;
        shift_clock = 1'b0;
        shift_clear_n = 1'b1;
        store_clock = 1'b0;
        output_enable_n = 1'b1; // Pulled up so pins float at power up
    end
    task automatic half();
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic set_pins(input logic clr_n, input logic oe_n);
        @(posedge clk);
        #1;
        shift_clear_n = clr_n;
        output_enable_n = oe_n;
    endtask
    // One link clock period; clocks stand low outside frames
    // Ten clk, 80 ns: bit shown three clk before the rise, clocks high
    // for five, bit withdrawn at the fall
    task automatic pulse(input logic b, input logic sh, input logic st);
        repeat (2) @(posedge clk);
        #1;
        serial_data_in = b;
        repeat (3) @(posedge clk);
        #1;
        shift_clock = sh;
        store_clock = st;
        half();
        shift_clock = 1'b0;
        store_clock = 1'b0;
        serial_data_in = ~b; // Hold time over: bit no longer shown
    endtask
endmodule

// >>> sim/sipo_latch_bench.sv
/* Bench for the latch: random bytes, clear, tied clocks, enable,
   FIFO fill past full and drain. Assumes host model and checker. */
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("unexpected %s exp %h got %h", what, exp, got); \
    end end
module sipo_latch_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic store_ready = 1'b0;
    logic serial_data_in, shift_clock, shift_clear_n, store_clock;
    logic output_enable_n, cascade_out, store_valid, b;
    logic [7:0] par_out, par_oe, store_data, stg, last, e;
    logic [7:0] q[$];
    int compares = 0;
    int n_mismatch = 0;
    always #4 clk = ~clk;
    sipo_host host (.clk, .serial_data_in, .shift_clock, .shift_clear_n,
        .store_clock, .output_enable_n);
    sipo_latch dut (.clk, .arst_n, .serial_data_in, .shift_clock,
        .shift_clear_n, .store_clock, .output_enable_n, .par_out, .par_oe,
        .cascade_out, .store_valid, .store_ready, .store_data);
    function automatic logic [7:0] shifted(input logic [7:0] s,
        input logic b);
        return {s[6:0], b};
    endfunction
    task automatic clock(input logic bit_in, input logic sh, input logic st);
        host.pulse(bit_in, sh, st);
        if (st) begin
            if (q.size() < 8) q.push_back(stg); // Full FIFO drops it
            last = stg;
        end
        if (sh) stg = shifted(stg, bit_in);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(3));
        stg = 8'h00;
        repeat (20) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (10) @(posedge clk);
        host.set_pins(1'b1, 1'b0);
        for (int n = 0; n < 5; n++) begin
            e = (n == 0) ? 8'hA5 : 8'($urandom);
            for (int i = 7; i >= 0; i--) clock(e[i], 1'b1, 1'b0);
            `CHK("cascade", e[7], cascade_out)
            clock(1'b0, 1'b0, 1'b1);
            `CHK("parallel", e, par_out)
            `CHK("enable", 8'hFF, par_oe)
        end
        for (int i = 7; i >= 0; i--) clock(~e[i], 1'b1, 1'b0);
        `CHK("held", last, par_out)
        host.set_pins(1'b0, 1'b1);
        repeat (8) @(posedge clk);
        `CHK("cleared", 1'b0, cascade_out)
        `CHK("kept", last, par_out)
        `CHK("float", 8'h00, par_oe)
        stg = 8'h00;
        host.set_pins(1'b1, 1'b0);
        clock(1'b1, 1'b0, 1'b1);
        `CHK("zeroed", 8'h00, par_out)
        for (int i = 0; i < 8; i++) begin
            b = 1'($urandom);
            clock(b, 1'b1, 1'b1);
            `CHK("lag", last, par_out)
        end
        for (int t = 0; t < 300 && q.size() > 0; t++) begin
            @(negedge clk);
            if (store_valid === 1'b1 && store_ready === 1'b1) begin
                e = q.pop_front();
                `CHK("fifo", e, store_data)
            end
            @(posedge clk);
            #1 store_ready = 1'($urandom);
        end
        if (q.size() != 0) n_mismatch++;
        repeat (3) @(posedge clk);
        `CHK("empty", 1'b0, store_valid)
        results();
    end
endmodule
bind sipo_latch sipo_latch_assertions chk (.*);
